/* link_core_pkg.sv */
// Constants for the link core control register bank
package link_core_pkg;
  localparam logic [31:0] ADDR_CONTROL = 32'h4000_0000;
  localparam logic [31:0] ADDR_INT_MASK = 32'h4000_000c;
  localparam logic [31:0] ADDR_INT_STAT = 32'h4000_0010;
  localparam logic [31:0] ADDR_INT_ACK = 32'h4000_0018;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;
  // Command bits
  localparam int CORE_RESET_BIT = 31;
  localparam int TIMING_RESET_BIT = 30;
  localparam int REGS_RESET_BIT = 29;
  localparam int SW_INT_BIT = 28;
  localparam int RF_ABORT_BIT = 26;
  localparam int ADV_ABORT_BIT = 25;
  localparam int SCAN_ABORT_BIT = 24;
  // Static bits
  localparam int MORE_DATA_BIT = 22;
  localparam int SEQNUM_BIT = 21;
  localparam int ACK_SCHEME_BIT = 20;
  localparam int CIPHER_BIT = 19;
  localparam int WHITENING_BIT = 18;
  localparam int CRC_STRIP_BIT = 17;
  localparam int HOP_REMAP_BIT = 16;
  localparam int SPARE_HI_BIT = 13;
  localparam int SPARE_LO_BIT = 12;
  localparam int ADV_FILTER_BIT = 9;
  // Software interrupt mask, status and acknowledge position
  localparam int SW_INT_MASK_BIT = 9;
  localparam logic [31:0] STATIC_BITS_MASK = 32'h007f_3200;
  typedef enum logic [3:0] {
    RT_IDLE = 4'b0001,
    RT_WAIT_BYTE = 4'b0010,
    RT_WAIT_PACKET = 4'b0100,
    RT_FINISH = 4'b1000
  } rf_abort_state_t;
endpackage

/* link_core_control.sv */
// APB register bank holding the link core main control register
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Writing one to bit 31 pulses core reset; bit self-clears; zero write ignored.
// - Writing one to bit 30 pulses timing generator reset; self-clears; zero ignored.
// - Writing one to bit 29 resets the register block; self-clears; zero ignored.
// - Register block reset keeps interrupt status; software acknowledges it afterwards.
// - Writing one to bit 28 raises software interrupt when masked in; self-clears.
// - Writing one to bit 26 aborts the running RF test; self-clears.
// - Infinite transmit abort finishes current byte, then stops and finalises the CRC in the same cycle.
// - Infinite receive abort ends packet if address seen, else stops at once; radio off either way.
// - Writing one to bit 25 aborts the advertising event; self-clears.
// - Writing one to bit 24 aborts the scan window; self-clears.
// - Bit 22 limits to one exchange regardless of more-data bits.
// - Bit 21 disables sequence numbering and its receive errors.
// - Bit 20 disables the acknowledge scheme and its receive errors.
// - Bit 19 disables packet ciphering; clear means normal ciphering.
// - Cipher disabled with connection cipher enabled still makes MIC, plain payload.
// - Bit 18 set disables whitening both directions.
// - Bit 17 set keeps received CRC and sends zero CRC.
// - Bit 16 set disables hop channel remapping.
// - Advertising filter enable reports only error-free advertising packets.
module link_core_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic test_tx_infinite,
  input wire logic test_rx_infinite,
  input wire logic tx_byte_end,
  input wire logic rx_access_addr_seen,
  input wire logic rx_packet_end,
  input wire logic conn_cipher_enable,
  output logic core_soft_reset,
  output logic timing_gen_reset_cmd,
  output logic advertising_abort_cmd,
  output logic scan_abort_cmd,
  output logic rf_test_stop,
  output logic tx_crc_finalize,
  output logic radio_off,
  output logic software_irq_out,
  output logic more_data_disable,
  output logic seqnum_disable,
  output logic ack_scheme_disable,
  output logic cipher_disable,
  output logic payload_encrypt,
  output logic mic_generate,
  output logic whitening_disable,
  output logic crc_strip_disable,
  output logic tx_crc_zero,
  output logic hop_remap_disable,
  output logic adv_error_filter_enable
);
  logic [31:0] control;
  logic int_mask;
  logic int_stat;
  logic regs_reset;
  logic rf_abort_done;
  logic access;
  logic wr;
  link_core_pkg::rf_abort_state_t rf_state;
  link_core_pkg::rf_abort_state_t next_rf_state;

  // Answer one wait state after the access phase starts
  assign access = psel && penable && !pready;
  assign wr = access && pwrite;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (access)
      begin
        unique case (paddr)
          link_core_pkg::ADDR_CONTROL:
          begin
            if (!pwrite)
            begin
              prdata <= control;
            end
          end
          link_core_pkg::ADDR_INT_MASK:
          begin
            if (!pwrite)
            begin
              prdata[link_core_pkg::SW_INT_MASK_BIT] <= int_mask;
            end
          end
          link_core_pkg::ADDR_INT_STAT:
          begin
            if (!pwrite)
            begin
              prdata[link_core_pkg::SW_INT_MASK_BIT] <= int_stat;
            end
          end
          link_core_pkg::ADDR_INT_ACK:
          begin
          end
          default:
          begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Register block reset is held one cycle so the clearing write is seen as done
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      regs_reset <= 1'b0;
    end
    else
    begin
      regs_reset <= wr && (paddr == link_core_pkg::ADDR_CONTROL)
        && pwdata[link_core_pkg::REGS_RESET_BIT];
    end
  end

  // Control register: static bits plus self-clearing commands
  always_ff @(posedge clk)
  begin
    if (reset || regs_reset)
    begin
      control <= link_core_pkg::CONTROL_RESET;
    end
    else
    begin
      // One-cycle commands clear after their pulse; zero writes leave them alone
      control[link_core_pkg::CORE_RESET_BIT] <= 1'b0;
      control[link_core_pkg::TIMING_RESET_BIT] <= 1'b0;
      control[link_core_pkg::SW_INT_BIT] <= 1'b0;
      control[link_core_pkg::ADV_ABORT_BIT] <= 1'b0;
      control[link_core_pkg::SCAN_ABORT_BIT] <= 1'b0;
      if (rf_abort_done)
      begin
        control[link_core_pkg::RF_ABORT_BIT] <= 1'b0;
      end
      if (wr && (paddr == link_core_pkg::ADDR_CONTROL))
      begin
        control <= (control & ~link_core_pkg::STATIC_BITS_MASK)
          | (pwdata & link_core_pkg::STATIC_BITS_MASK);
        control[link_core_pkg::CORE_RESET_BIT] <= pwdata[link_core_pkg::CORE_RESET_BIT];
        control[link_core_pkg::TIMING_RESET_BIT] <=
          pwdata[link_core_pkg::TIMING_RESET_BIT];
        control[link_core_pkg::REGS_RESET_BIT] <= pwdata[link_core_pkg::REGS_RESET_BIT];
        control[link_core_pkg::SW_INT_BIT] <= pwdata[link_core_pkg::SW_INT_BIT];
        control[link_core_pkg::ADV_ABORT_BIT] <= pwdata[link_core_pkg::ADV_ABORT_BIT];
        control[link_core_pkg::SCAN_ABORT_BIT] <= pwdata[link_core_pkg::SCAN_ABORT_BIT];
        // The whole-word update above would otherwise undo a clear due this cycle
        if (pwdata[link_core_pkg::RF_ABORT_BIT])
        begin
          control[link_core_pkg::RF_ABORT_BIT] <= 1'b1;
        end
        else if (rf_abort_done)
        begin
          control[link_core_pkg::RF_ABORT_BIT] <= 1'b0;
        end
      end
    end
  end

  localparam logic INT_MASK_RESET_BIT =
    link_core_pkg::INT_MASK_RESET[link_core_pkg::SW_INT_MASK_BIT];

  // Mask is part of the register block; status is not, so it survives bit 29
  always_ff @(posedge clk)
  begin
    if (reset || regs_reset)
    begin
      int_mask <= INT_MASK_RESET_BIT;
    end
    else if (wr && (paddr == link_core_pkg::ADDR_INT_MASK))
    begin
      int_mask <= pwdata[link_core_pkg::SW_INT_MASK_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      int_stat <= 1'b0;
    end
    else if (control[link_core_pkg::SW_INT_BIT] && int_mask)
    begin
      int_stat <= 1'b1;
    end
    else if (wr && (paddr == link_core_pkg::ADDR_INT_ACK)
      && pwdata[link_core_pkg::SW_INT_MASK_BIT])
    begin
      int_stat <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      software_irq_out <= 1'b0;
    end
    else
    begin
      software_irq_out <= int_stat && int_mask;
    end
  end

  // RF test abort sequencer
  always_comb
  begin
    next_rf_state = rf_state;
    unique case (rf_state)
      link_core_pkg::RT_IDLE:
      begin
        if (control[link_core_pkg::RF_ABORT_BIT])
        begin
          if (test_tx_infinite)
          begin
            next_rf_state = link_core_pkg::RT_WAIT_BYTE;
          end
          else if (test_rx_infinite && rx_access_addr_seen)
          begin
            next_rf_state = link_core_pkg::RT_WAIT_PACKET;
          end
          else
          begin
            next_rf_state = link_core_pkg::RT_FINISH;
          end
        end
      end
      link_core_pkg::RT_WAIT_BYTE:
      begin
        if (tx_byte_end)
        begin
          next_rf_state = link_core_pkg::RT_FINISH;
        end
      end
      link_core_pkg::RT_WAIT_PACKET:
      begin
        if (rx_packet_end)
        begin
          next_rf_state = link_core_pkg::RT_FINISH;
        end
      end
      link_core_pkg::RT_FINISH:
      begin
        next_rf_state = link_core_pkg::RT_IDLE;
      end
      default:
      begin
        next_rf_state = link_core_pkg::RT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rf_state <= link_core_pkg::RT_IDLE;
    end
    else
    begin
      rf_state <= next_rf_state;
    end
  end

  assign rf_abort_done = (rf_state == link_core_pkg::RT_FINISH);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rf_test_stop <= 1'b0;
      tx_crc_finalize <= 1'b0;
      radio_off <= 1'b0;
    end
    else
    begin
      rf_test_stop <= (rf_state != link_core_pkg::RT_FINISH)
        && (next_rf_state == link_core_pkg::RT_FINISH);
      tx_crc_finalize <= (rf_state == link_core_pkg::RT_WAIT_BYTE) && tx_byte_end;
      radio_off <= (next_rf_state == link_core_pkg::RT_FINISH)
        && (rf_state != link_core_pkg::RT_WAIT_BYTE)
        && (rf_state != link_core_pkg::RT_FINISH);
    end
  end

  // Registered copies of commands and static fields toward the core
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      core_soft_reset <= 1'b0;
      timing_gen_reset_cmd <= 1'b0;
      advertising_abort_cmd <= 1'b0;
      scan_abort_cmd <= 1'b0;
      more_data_disable <= 1'b0;
      seqnum_disable <= 1'b0;
      ack_scheme_disable <= 1'b0;
      cipher_disable <= 1'b0;
      payload_encrypt <= 1'b0;
      mic_generate <= 1'b0;
      whitening_disable <= 1'b0;
      crc_strip_disable <= 1'b0;
      tx_crc_zero <= 1'b0;
      hop_remap_disable <= 1'b0;
      adv_error_filter_enable <= 1'b0;
    end
    else
    begin
      core_soft_reset <= control[link_core_pkg::CORE_RESET_BIT];
      timing_gen_reset_cmd <= control[link_core_pkg::TIMING_RESET_BIT];
      advertising_abort_cmd <= control[link_core_pkg::ADV_ABORT_BIT];
      scan_abort_cmd <= control[link_core_pkg::SCAN_ABORT_BIT];
      more_data_disable <= control[link_core_pkg::MORE_DATA_BIT];
      seqnum_disable <= control[link_core_pkg::SEQNUM_BIT];
      ack_scheme_disable <= control[link_core_pkg::ACK_SCHEME_BIT];
      cipher_disable <= control[link_core_pkg::CIPHER_BIT];
      payload_encrypt <= conn_cipher_enable && !control[link_core_pkg::CIPHER_BIT];
      mic_generate <= conn_cipher_enable;
      whitening_disable <= control[link_core_pkg::WHITENING_BIT];
      crc_strip_disable <= control[link_core_pkg::CRC_STRIP_BIT];
      tx_crc_zero <= control[link_core_pkg::CRC_STRIP_BIT];
      hop_remap_disable <= control[link_core_pkg::HOP_REMAP_BIT];
      adv_error_filter_enable <= control[link_core_pkg::ADV_FILTER_BIT];
    end
  end

  a_core_reset_pulse: assert property (@(posedge clk) disable iff (reset)
    wr && paddr == link_core_pkg::ADDR_CONTROL && pwdata[link_core_pkg::CORE_RESET_BIT]
    |=> ##1 core_soft_reset ##1 !core_soft_reset)
    else $error("core reset pulse wrong");

  a_timing_reset_pulse: assert property (@(posedge clk) disable iff (reset)
    $rose(timing_gen_reset_cmd) |=> !timing_gen_reset_cmd)
    else $error("timing reset not one cycle");

  a_regs_reset_clears: assert property (@(posedge clk) disable iff (reset)
    regs_reset |=> control == link_core_pkg::CONTROL_RESET && !int_mask)
    else $error("register block not cleared");

  a_status_survives: assert property (@(posedge clk) disable iff (reset)
    regs_reset && int_stat |=> int_stat)
    else $error("status lost on block reset");

  a_sw_irq_raise: assert property (@(posedge clk) disable iff (reset)
    control[link_core_pkg::SW_INT_BIT] && int_mask |=> ##1 software_irq_out)
    else $error("software interrupt not raised");

  a_rf_abort_holds: assert property (@(posedge clk) disable iff (reset)
    control[link_core_pkg::RF_ABORT_BIT] && !rf_abort_done && !regs_reset
    |=> control[link_core_pkg::RF_ABORT_BIT])
    else $error("rf abort bit cleared early");

  a_tx_byte_crc: assert property (@(posedge clk) disable iff (reset)
    rf_state == link_core_pkg::RT_WAIT_BYTE && tx_byte_end |=> tx_crc_finalize && rf_test_stop)
    else $error("tx abort crc step missing");

  a_rx_no_aa_off: assert property (@(posedge clk) disable iff (reset)
    rf_state == link_core_pkg::RT_IDLE && control[link_core_pkg::RF_ABORT_BIT] && !test_tx_infinite
    && !rx_access_addr_seen |=> radio_off)
    else $error("radio not switched off");

  a_adv_abort_pulse: assert property (@(posedge clk) disable iff (reset)
    control[link_core_pkg::ADV_ABORT_BIT]
    |=> !control[link_core_pkg::ADV_ABORT_BIT] || $past(wr))
    else $error("advertising abort stuck");

  a_payload_plain: assert property (@(posedge clk) disable iff (reset)
    control[link_core_pkg::CIPHER_BIT] && conn_cipher_enable |=> mic_generate && !payload_encrypt)
    else $error("cipher disable mishandled");
endmodule // link_core_control
`default_nettype wire

/* dummy_end_marker_unused.sv */
// Intentionally empty compile unit
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* ble_link_core_control_reg_test.sv */
// Self-checking testbench for the link core control register bank
`timescale 1ns/1ns
`default_nettype none
module ble_link_core_control_reg_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic test_tx_infinite = 1'b0, test_rx_infinite = 1'b0, tx_byte_end = 1'b0;
  logic rx_access_addr_seen = 1'b0, rx_packet_end = 1'b0, conn_cipher_enable = 1'b0;
  logic core_soft_reset, timing_gen_reset_cmd, advertising_abort_cmd, scan_abort_cmd;
  logic rf_test_stop, tx_crc_finalize, radio_off, software_irq_out;
  logic more_data_disable, seqnum_disable, ack_scheme_disable, cipher_disable;
  logic payload_encrypt, mic_generate, whitening_disable, crc_strip_disable;
  logic tx_crc_zero, hop_remap_disable, adv_error_filter_enable;
  int fail_count = 0;
  int comparisons = 0;
  int cnt [7] = '{0, 0, 0, 0, 0, 0, 0};
  int snap [7];
  int cbit [4] = '{31, 30, 25, 24};
  logic [6:0] pulses;
  logic [31:0] rd, v;
  logic err;

  always #50 clk = ~clk;

  link_core_control dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_tx_infinite(test_tx_infinite), .test_rx_infinite(test_rx_infinite),
    .tx_byte_end(tx_byte_end), .rx_access_addr_seen(rx_access_addr_seen),
    .rx_packet_end(rx_packet_end), .conn_cipher_enable(conn_cipher_enable),
    .core_soft_reset(core_soft_reset), .timing_gen_reset_cmd(timing_gen_reset_cmd),
    .advertising_abort_cmd(advertising_abort_cmd), .scan_abort_cmd(scan_abort_cmd),
    .rf_test_stop(rf_test_stop), .tx_crc_finalize(tx_crc_finalize), .radio_off(radio_off),
    .software_irq_out(software_irq_out), .more_data_disable(more_data_disable),
    .seqnum_disable(seqnum_disable), .ack_scheme_disable(ack_scheme_disable),
    .cipher_disable(cipher_disable), .payload_encrypt(payload_encrypt),
    .mic_generate(mic_generate), .whitening_disable(whitening_disable),
    .crc_strip_disable(crc_strip_disable), .tx_crc_zero(tx_crc_zero),
    .hop_remap_disable(hop_remap_disable),
    .adv_error_filter_enable(adv_error_filter_enable)
  );

  // Pulse counters let command checks ignore the exact launch cycle
  assign pulses = {radio_off, tx_crc_finalize, rf_test_stop, scan_abort_cmd,
                   advertising_abort_cmd, timing_gen_reset_cmd, core_soft_reset};
  always @(posedge clk)
  begin
    for (int i = 0; i < 7; i++)
      if (pulses[i] === 1'b1)
        cnt[i] <= cnt[i] + 1;
  end

  function automatic logic [31:0] exp_outs(logic [31:0] w, logic cce);
    return {21'h0, w[22:16], w[9], w[17], cce & ~w[19], cce};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      $display("ERROR at %0t: pready got %h expected %h", $time, pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
    check(err, exp_err);
  endtask

  task automatic take;
    snap = cnt;
  endtask

  task automatic delta(input int i, input int exp);
    check(32'(cnt[i] - snap[i]), 32'(exp));
  endtask

  // Abort of an RF test in transmit, receive with address, receive without
  task automatic rf_abort(input logic tx, input logic rx, input logic aa);
    test_tx_infinite <= tx;
    test_rx_infinite <= rx;
    rx_access_addr_seen <= aa;
    take();
    apb(1'b1, link_core_pkg::ADDR_CONTROL, 32'h0400_0000);
    wt(3);
    rdchk(link_core_pkg::ADDR_CONTROL, {5'h0, tx | (rx & aa), 26'h0}, 1'b0);
    @(posedge clk);
    tx_byte_end <= tx;
    rx_packet_end <= rx & aa;
    @(posedge clk);
    tx_byte_end <= 1'b0;
    rx_packet_end <= 1'b0;
    wt(4);
    delta(4, 1);
    delta(5, tx);
    delta(6, rx);
    rdchk(link_core_pkg::ADDR_CONTROL, 32'h0000_0000, 1'b0);
    test_tx_infinite <= 1'b0;
    test_rx_infinite <= 1'b0;
    rx_access_addr_seen <= 1'b0;
  endtask

  initial
  begin
    #300000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    void'($urandom(73));
    wt(5);
    reset <= 1'b0;
    rdchk(link_core_pkg::ADDR_CONTROL, link_core_pkg::CONTROL_RESET, 1'b0);
    rdchk(link_core_pkg::ADDR_INT_MASK, link_core_pkg::INT_MASK_RESET, 1'b0);
    rdchk(32'h4000_0004, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 32'h00ff_ffff : (i == 1) ? 32'h0000_0000 : $urandom & 32'h00ff_ffff;
      conn_cipher_enable <= 1'($urandom);
      apb(1'b1, link_core_pkg::ADDR_CONTROL, v);
      wt(2);
      rdchk(link_core_pkg::ADDR_CONTROL, v & link_core_pkg::STATIC_BITS_MASK, 1'b0);
      check({21'h0, more_data_disable, seqnum_disable, ack_scheme_disable, cipher_disable,
             whitening_disable, crc_strip_disable, hop_remap_disable, adv_error_filter_enable,
             tx_crc_zero, payload_encrypt, mic_generate},
            exp_outs(v, conn_cipher_enable));
    end
    take();
    apb(1'b1, link_core_pkg::ADDR_CONTROL, 32'h0000_0000);
    wt(4);
    for (int j = 0; j < 7; j++)
      delta(j, 0);
    for (int k = 0; k < 4; k++)
    begin
      take();
      apb(1'b1, link_core_pkg::ADDR_CONTROL, 32'h1 << cbit[k]);
      wt(4);
      for (int j = 0; j < 4; j++)
        delta(j, j == k);
      rdchk(link_core_pkg::ADDR_CONTROL, 32'h0000_0000, 1'b0);
    end
    rf_abort(1'b1, 1'b0, 1'b0);
    rf_abort(1'b0, 1'b1, 1'b1);
    rf_abort(1'b0, 1'b1, 1'b0);
    // Masked out: the request leaves neither status nor output behind
    apb(1'b1, link_core_pkg::ADDR_CONTROL, 32'h1000_0000);
    wt(3);
    check(software_irq_out, 1'b0);
    rdchk(link_core_pkg::ADDR_INT_STAT, 32'h0000_0000, 1'b0);
    apb(1'b1, link_core_pkg::ADDR_INT_MASK, 32'h0000_0200);
    wt(2);
    check(software_irq_out, 1'b0);
    apb(1'b1, link_core_pkg::ADDR_CONTROL, 32'h1000_0000);
    wt(3);
    check(software_irq_out, 1'b1);
    rdchk(link_core_pkg::ADDR_INT_STAT, 32'h0000_0200, 1'b0);
    rdchk(link_core_pkg::ADDR_CONTROL, 32'h0000_0000, 1'b0);
    apb(1'b1, link_core_pkg::ADDR_CONTROL, 32'h2001_0200);
    wt(3);
    rdchk(link_core_pkg::ADDR_CONTROL, 32'h0000_0000, 1'b0);
    rdchk(link_core_pkg::ADDR_INT_MASK, 32'h0000_0000, 1'b0);
    rdchk(link_core_pkg::ADDR_INT_STAT, 32'h0000_0200, 1'b0);
    check(software_irq_out, 1'b0);
    apb(1'b1, link_core_pkg::ADDR_INT_ACK, 32'h0000_0200);
    apb(1'b1, link_core_pkg::ADDR_INT_STAT, 32'hffff_ffff);
    rdchk(link_core_pkg::ADDR_INT_STAT, 32'h0000_0000, 1'b0);
    apb(1'b1, 32'h4000_0020, 32'hffff_ffff);
    check(err, 1'b1);
    end_sim();
  end
endmodule // ble_link_core_control_reg_test
`default_nettype wire
